/* verilog/flash_pin_pkg.sv */
// How it works
// - Hold level polarity follows config bit ten
// - Hold drives only with select and enable low
// - Sync burst: hold asserted means data invalid
// - Hold deasserted in async reads and writes
// - Sync: latch on strobe rise or clock
// - Async: latch on strobe rise, flow while strobe low
// - Die select low activates, high floats outputs
// - Output enable high floats data and hold
// - Address width 24 or 25 bits, bit zero lowest
// - Top address bit high selects top die
// - Reset gives async array reads, blocks writes
// - Write latched on first strobe or select rise
package flash_pin_pkg;
  localparam int DATA_W = 16;             // Data bus width
  localparam int ADDR_W_SMALL = 24;       // Single die address width
  localparam int ADDR_W_LARGE = 25;       // Dual die address width
  localparam int TOP_DIE_BIT = 24;        // Address bit that picks the top die
  localparam int HOLD_POL_BIT = 10;       // Polarity bit inside the read config word
  localparam int CFG_W = 16;              // Read config word width
  localparam int CTRL_W = 5;              // Synchronised control pins
  localparam logic [CTRL_W-1:0] CTRL_RST = 5'h0f; // Strobes idle high, bus clock low
  localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;

  // Read mode of the die, one-hot
  typedef enum logic [1:0] {
    MODE_ASYNC = 2'b01,
    MODE_SYNC = 2'b10
  } read_mode_t;
endpackage

/* verilog/pin_sync.sv */
`timescale 1ns/100ps
// Two flop synchroniser for pins from outside the clock domain
module pin_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r; // First stage, read only by the second

  // Both stages share reset and enable
  always_ff @(posedge clk) begin
    if (!nrst) begin
      meta_r <= RST_VAL;
      q <= RST_VAL;
    end else if (ce) begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule

/* verilog/flash_bus_pins.sv */
`timescale 1ns/100ps
// Pin side control of a parallel flash die: address latch, write capture,
// output drive enables and the data-valid hold indicator.
module flash_bus_pins
  import flash_pin_pkg::*;
#(
  parameter int ADDR_W = flash_pin_pkg::ADDR_W_LARGE,
  parameter bit TWO_DIE = 1'b1
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  // Host pins
  input wire logic [ADDR_W-1:0] addr_pin,
  input wire logic addr_valid_n,
  input wire logic die_select_n,
  input wire logic die_output_drive_n,
  input wire logic write_strobe_n,
  input wire logic bus_clk,
  input wire logic [flash_pin_pkg::DATA_W-1:0] dq_in,
  output logic [flash_pin_pkg::DATA_W-1:0] dq_out,
  output logic dq_oe,
  output logic hold_out,
  output logic hold_oe,
  // Core side, same clock
  input wire logic [flash_pin_pkg::CFG_W-1:0] read_config_reg,
  input wire logic sync_read_req,
  input wire logic core_data_ready,
  input wire logic [flash_pin_pkg::DATA_W-1:0] core_rd_data,
  output logic [ADDR_W-1:0] addr_latched,
  output logic addr_strobe,
  output logic top_die_sel,
  output logic die_active,
  output logic sync_mode_active,
  output logic wr_valid,
  output logic [ADDR_W-1:0] wr_addr,
  output logic [flash_pin_pkg::DATA_W-1:0] wr_data
);
  import flash_pin_pkg::*;

  // Only the two documented address widths are served
  initial begin
    if (ADDR_W != ADDR_W_SMALL && ADDR_W != ADDR_W_LARGE) begin
      $error("ADDR_W must be 24 or 25");
    end
    if (TWO_DIE && ADDR_W != ADDR_W_LARGE) begin
      $error("Dual die needs the wide address");
    end
  end

  // Synchronised pins
  logic [CTRL_W-1:0] ctrl_s;
  logic [ADDR_W-1:0] addr_s; // Bit zero is the lowest address bit
  logic [DATA_W-1:0] dq_s;
  logic adv_n_s; // Address strobe
  logic cs_n_s; // Die select
  logic oe_n_s; // Output drive enable
  logic we_n_s; // Write strobe
  logic bclk_s; // Bus clock level

  // Control pins travel together so their relative order survives
  pin_sync #(.W(CTRL_W), .RST_VAL(CTRL_RST)) u_ctrl_sync (
    .clk(clk),
    .nrst(nrst),
    .ce(ce),
    .d({bus_clk, write_strobe_n, die_output_drive_n, die_select_n, addr_valid_n}),
    .q(ctrl_s)
  );

  // Address and data take the same two stages as the strobes
  pin_sync #(.W(ADDR_W)) u_addr_sync (
    .clk(clk),
    .nrst(nrst),
    .ce(ce),
    .d(addr_pin),
    .q(addr_s)
  );

  pin_sync #(.W(DATA_W)) u_data_sync (
    .clk(clk),
    .nrst(nrst),
    .ce(ce),
    .d(dq_in),
    .q(dq_s)
  );

  assign adv_n_s = ctrl_s[0];
  assign cs_n_s = ctrl_s[1];
  assign oe_n_s = ctrl_s[2];
  assign we_n_s = ctrl_s[3];
  assign bclk_s = ctrl_s[4];

  // Previous samples for edge detection
  logic adv_n_prev_r;
  logic bclk_prev_r;
  logic wr_act_prev_r;

  // Read mode and address capture state
  read_mode_t mode_r, mode_nxt;
  logic adv_done_r, adv_done_nxt; // Address already taken in this strobe-low phase
  logic [ADDR_W-1:0] addr_r, addr_nxt;
  logic [ADDR_W-1:0] wa_r; // Write address tracked while the write is open
  logic [DATA_W-1:0] wd_r; // Write data tracked while the write is open

  // Decoded conditions
  wire selected = !cs_n_s;
  wire drive_ok = selected && !oe_n_s;
  wire read_cycle = drive_ok && we_n_s;
  wire is_sync = (mode_r == MODE_SYNC);
  wire adv_low = !adv_n_s;
  wire adv_rise = adv_n_s && !adv_n_prev_r;
  wire bclk_rise = is_sync && bclk_s && !bclk_prev_r;
  wire wr_act = selected && !we_n_s;
  wire wr_end = wr_act_prev_r && !wr_act;
  wire sync_take = is_sync && !adv_done_r && (adv_rise || (bclk_rise && adv_low));
  wire async_flow = !is_sync && adv_low;
  wire async_take = !is_sync && adv_rise;
  wire hold_assert = is_sync && read_cycle && !core_data_ready;
  wire hold_pol = read_config_reg[HOLD_POL_BIT];

  // Polarity maps the abstract assert onto a pin level
  function automatic logic hold_level(input logic asserted, input logic pol);
    hold_level = pol ? asserted : !asserted;
  endfunction

  // Mode only changes while the die is idle, so a burst is never cut
  always_comb begin
    mode_nxt = mode_r;
    case (mode_r)
      MODE_ASYNC: begin
        if (!selected && sync_read_req) begin
          mode_nxt = MODE_SYNC;
        end
      end
      MODE_SYNC: begin
        if (!selected && !sync_read_req) begin
          mode_nxt = MODE_ASYNC;
        end
      end
      default: begin
        mode_nxt = MODE_ASYNC;
      end
    endcase
  end

  // Address latch: flow, capture or hold
  always_comb begin
    addr_nxt = addr_r;
    adv_done_nxt = adv_done_r;
    if (sync_take || async_flow || async_take) begin
      addr_nxt = addr_s;
    end
    if (!adv_low) begin
      // New strobe-low phase may capture again
      adv_done_nxt = 1'b0;
    end else if (sync_take) begin
      adv_done_nxt = 1'b1;
    end
  end

  // Edge history
  always_ff @(posedge clk) begin
    if (!nrst) begin
      adv_n_prev_r <= 1'b1;
      bclk_prev_r <= 1'b0;
      wr_act_prev_r <= 1'b0;
    end else if (ce) begin
      adv_n_prev_r <= adv_n_s;
      bclk_prev_r <= bclk_s;
      wr_act_prev_r <= wr_act;
    end
  end

  // Reset always lands in async array reads
  always_ff @(posedge clk) begin
    if (!nrst) begin
      mode_r <= MODE_ASYNC;
      adv_done_r <= 1'b0;
      addr_r <= '0;
    end else if (ce) begin
      mode_r <= mode_nxt;
      adv_done_r <= adv_done_nxt;
      addr_r <= addr_nxt;
    end
  end

  // Write tracking: the last values before the first rise of strobe or select win
  always_ff @(posedge clk) begin
    if (!nrst) begin
      wa_r <= '0;
      wd_r <= DATA_RST;
    end else if (ce && wr_act) begin
      wa_r <= addr_s;
      wd_r <= dq_s;
    end
  end

  // Write capture; held in reset, so no write can slip through
  always_ff @(posedge clk) begin
    if (!nrst) begin
      wr_valid <= 1'b0;
      wr_addr <= '0;
      wr_data <= DATA_RST;
    end else if (ce) begin
      wr_valid <= wr_end;
      if (wr_end) begin
        wr_addr <= wa_r;
        wr_data <= wd_r;
      end
    end
  end

  // Address side outputs
  always_ff @(posedge clk) begin
    if (!nrst) begin
      addr_latched <= '0;
      addr_strobe <= 1'b0;
      top_die_sel <= 1'b0;
    end else if (ce) begin
      addr_latched <= addr_nxt;
      addr_strobe <= sync_take || async_take;
      top_die_sel <= TWO_DIE && addr_nxt[ADDR_W-1];
    end
  end

  // Pin drive; data from the core is registered once before it leaves
  always_ff @(posedge clk) begin
    if (!nrst) begin
      dq_out <= DATA_RST;
      dq_oe <= 1'b0;
      hold_out <= 1'b0;
      hold_oe <= 1'b0;
      die_active <= 1'b0;
      sync_mode_active <= 1'b0;
    end else if (ce) begin
      dq_out <= core_rd_data;
      dq_oe <= read_cycle;
      hold_out <= hold_level(hold_assert, hold_pol);
      hold_oe <= drive_ok;
      die_active <= selected;
      sync_mode_active <= (mode_nxt == MODE_SYNC);
    end
  end
endmodule

/* sim/flash_pins_chk.sv */
`timescale 1ns/100ps
// Pin timing checks; pins take up to four cycles to reach outputs
module flash_pins_chk
  import flash_pin_pkg::*;
#(
  parameter int ADDR_W = 25
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [ADDR_W-1:0] addr_pin,
  input wire logic addr_valid_n,
  input wire logic die_select_n,
  input wire logic die_output_drive_n,
  input wire logic write_strobe_n,
  input wire logic bus_clk,
  input wire logic [15:0] dq_in,
  input wire logic [15:0] read_config_reg,
  input wire logic core_data_ready,
  input wire logic dq_oe,
  input wire logic hold_out,
  input wire logic hold_oe,
  input wire logic [ADDR_W-1:0] addr_latched,
  input wire logic addr_strobe,
  input wire logic top_die_sel,
  input wire logic sync_mode_active,
  input wire logic wr_valid,
  input wire logic [ADDR_W-1:0] wr_addr,
  input wire logic [15:0] wr_data
);
  logic [3:0] age_r; // Cycles since reset, saturates at eight
  wire up = age_r[3]; // Synchroniser pipeline has settled
  wire sel = !die_select_n && !die_output_drive_n; // Read selected
  wire drv = sel && write_strobe_n; // Data drive wanted
  wire pol = read_config_reg[HOLD_POL_BIT]; // Asserted hold level
  // Age counter keeps reset leftovers out of the checks
  always_ff @(posedge clk) begin
    if (!nrst) begin
      age_r <= '0;
    end else if (!up) begin
      age_r <= age_r + 4'h1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst || !up);
  AST_HOLD_OE: assert property ($stable(sel)[*5] |-> hold_oe == sel)
    else $error("hold enable wrong");
  AST_DQ_OE: assert property ($stable(drv)[*5] |-> dq_oe == drv)
    else $error("data enable wrong");
  AST_HOLD_IDLE: assert property ((!sync_mode_active && $stable(pol))[*3] |-> hold_out == !pol)
    else $error("hold not idle");
  AST_HOLD_SYNC: assert property ((sync_mode_active && sel && write_strobe_n
    && $stable({pol, core_data_ready}))[*5] |-> hold_out == (pol ^ core_data_ready))
    else $error("hold wrong in burst");
  AST_ASYNC_CAP: assert property (!sync_mode_active && $rose(addr_valid_n)
    |-> ##[3:4] addr_strobe && addr_latched == addr_pin)
    else $error("async capture wrong");
  AST_SYNC_CAP: assert property (sync_mode_active && !addr_valid_n && $rose(bus_clk)
    |-> ##[3:4] addr_strobe && addr_latched == addr_pin)
    else $error("sync capture wrong");
  AST_NO_CLK: assert property (addr_valid_n[*6] |-> !addr_strobe)
    else $error("capture without strobe");
  AST_WR_CAP: assert property ($rose(write_strobe_n) && !die_select_n
    |-> ##[3:4] wr_valid && wr_addr == addr_pin && wr_data == dq_in)
    else $error("write capture wrong");
  AST_TOP_DIE: assert property (top_die_sel == addr_latched[TOP_DIE_BIT])
    else $error("die choice wrong");
  // Main traffic kinds
  cover property (sync_mode_active && addr_strobe);
  cover property (wr_valid);
  cover property (hold_oe && hold_out);
endmodule
bind flash_bus_pins flash_pins_chk #(.ADDR_W(ADDR_W)) chk_i (.clk, .nrst, .addr_pin, .addr_valid_n,
  .die_select_n, .die_output_drive_n, .write_strobe_n, .bus_clk, .dq_in, .read_config_reg,
  .core_data_ready, .dq_oe, .hold_out, .hold_oe, .addr_latched, .addr_strobe, .top_die_sel,
  .sync_mode_active, .wr_valid, .wr_addr, .wr_data);

/* sim/host_model.sv */
`timescale 1ns/100ps
// Host controller pins; steps land on falling clock edges
module host_model (
  input wire logic clk,
  output logic [24:0] addr_pin,
  output logic addr_valid_n,
  output logic die_select_n,
  output logic die_output_drive_n,
  output logic write_strobe_n,
  output logic bus_clk,
  output logic [15:0] dq_in
);
  // Parked: deselected, strobes high, bus clock still
  initial begin
    {addr_valid_n, die_output_drive_n, write_strobe_n, bus_clk} = 4'he;
    die_select_n = 1'b1;
    addr_pin = '0;
    dq_in = '0;
  end
  // Whole cycles; six cycles of hold outlast the pin pipeline
  task automatic st(input int n);
    repeat (n) @(negedge clk);
  endtask
  // Write: strobe rises first, select later
  task automatic wr(input logic [24:0] a, input logic [15:0] d);
    st(1);
    addr_pin = a;
    dq_in = d;
    {die_select_n, write_strobe_n} = 2'h0;
    st(4);
    write_strobe_n = 1'b1;
    st(6);
    die_select_n = 1'b1;
    dq_in = ~d; // Released bus shows inverse, never old value
  endtask
  // Read: clock edge, then address moves, then strobe rises
  task automatic rd(input logic [24:0] a);
    st(1);
    addr_pin = a;
    {die_select_n, addr_valid_n, die_output_drive_n} = 3'h0;
    st(3);
    bus_clk = 1'b1;
    st(6);
    bus_clk = 1'b0;
    addr_pin = a ^ 25'h1; // Moves while strobe still low
    st(3);
    addr_valid_n = 1'b1;
    st(6);
  endtask
  // Deselect, with a clock pulse that must be ignored
  task automatic idle();
    {die_output_drive_n, die_select_n, bus_clk} = 3'h7;
    addr_pin = ~addr_pin;
    st(3);
    bus_clk = 1'b0;
    st(6);
  endtask
endmodule

/* sim/testbench.sv */
`timescale 1ns/100ps
// Random write then read rounds, then a reset during a write
module testbench;
  import flash_pin_pkg::*;
  logic clk = 1'b0; // 200 MHz
  logic nrst = 1'b0;
  logic [15:0] read_config_reg = '0, core_rd_data = '0;
  logic sync_read_req = 1'b0, core_data_ready = 1'b0;
  wire [24:0] addr_pin;
  wire addr_valid_n, die_select_n, die_output_drive_n, write_strobe_n, bus_clk;
  wire [15:0] dq_in;
  logic [15:0] wr_data, dq_out;
  logic [24:0] addr_latched, wr_addr;
  logic dq_oe, hold_out, hold_oe, top_die_sel, die_active, sync_mode_active;
  int fails = 0, checks = 0, cyc = 0;
  always #2.5 clk = ~clk;
  flash_bus_pins dut (.clk, .nrst, .ce(1'b1), .addr_pin, .addr_valid_n, .die_select_n,
    .die_output_drive_n, .write_strobe_n, .bus_clk, .dq_in, .dq_out, .dq_oe, .hold_out,
    .hold_oe, .read_config_reg, .sync_read_req, .core_data_ready, .core_rd_data, .addr_latched,
    .addr_strobe(), .top_die_sel, .die_active, .sync_mode_active, .wr_valid(), .wr_addr, .wr_data);
  host_model host (.clk, .addr_pin, .addr_valid_n, .die_select_n, .die_output_drive_n,
    .write_strobe_n, .bus_clk, .dq_in);
  // Sync captures at the clock, async at the strobe rise
  function automatic logic [24:0] exp_addr(input logic s, input logic [24:0] a);
    return s ? a : a ^ 25'h1;
  endfunction
  // Burst: asserted while data not ready; otherwise idle level
  function automatic logic exp_hold(input logic s, input logic p, input logic r);
    return s ? p ^ r : !p;
  endfunction
  task automatic chk(input string n, input logic [24:0] seen, input logic [24:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic results();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Rounds take about 39 cycles each
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      fails++;
      results();
    end
  end
  initial begin
    logic [24:0] a;
    void'($urandom(32'h6760));
    repeat (12) @(negedge clk);
    nrst = 1'b1;
    for (int i = 0; i < 14; i++) begin
      a = (i == 0) ? 25'h1ffffff : (i == 1) ? 25'h0 : 25'($urandom);
      sync_read_req = (i < 4) ? i[0] : 1'($urandom);
      read_config_reg = 16'($urandom);
      core_data_ready = 1'($urandom);
      core_rd_data = 16'($urandom);
      host.wr(a, core_rd_data ^ 16'h5a5a);
      chk("wr_addr", wr_addr, a);
      chk("wr_data", 25'(wr_data), 25'(core_rd_data ^ 16'h5a5a));
      host.rd(~a);
      chk("addr_latched", addr_latched, exp_addr(sync_read_req, ~a));
      chk("top_die_sel", top_die_sel, !a[24]);
      chk("hold_oe", hold_oe, 1'b1);
      chk("dq_oe", dq_oe, 1'b1);
      chk("dq_out", 25'(dq_out), 25'(core_rd_data));
      chk("die_active", die_active, 1'b1);
      chk("hold_out", hold_out, exp_hold(sync_read_req, read_config_reg[HOLD_POL_BIT], core_data_ready));
      host.idle();
      chk("hold_oe", hold_oe, 1'b0);
      chk("dq_oe", dq_oe, 1'b0);
      chk("die_active", die_active, 1'b0);
      $display("test %0d done", i);
    end
    // Mode request dropped so the die stays in async reads after reset
    sync_read_req = 1'b0;
    nrst = 1'b0;
    host.wr(25'h0abcdef, 16'h1234);
    nrst = 1'b1;
    @(negedge clk);
    chk("sync_mode_active", sync_mode_active, 1'b0);
    chk("wr_data", 25'(wr_data), 25'h0);
    $display("test reset done");
    results();
  end
endmodule
